// ### logic/ohci_front_cfg.svh
/*
 * Offsets, field positions, reset values and constants of the front
 * register bank. Assumes byte addresses on a 32-bit Wishbone bus.
 */
`ifndef OHCI_FRONT_CFG_SVH
`define OHCI_FRONT_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_VERSION    8'h00
`define OFS_ROM_ACCESS 8'h04
`define OFS_RETRY      8'h08
`define OFS_CS_DATA    8'h0c
`define OFS_CS_CTRL    8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ROM_PRESENT 24
`define BIT_ROM_CLEAR   31
`define BIT_ROM_GO      25
`define BIT_CS_DONE     31

// ----------------------------------------------------------------
// Constant and reset values
// ----------------------------------------------------------------
`define VER_MAJOR      8'h01
`define VER_MINOR      8'h10
`define MINI_RST       8'h00
`define MINI_WORD_ADDR 8'h28
`define MINI_MIN_VALID 8'h39
`define RETRY_RST      4'h0
`define CS_DONE_RST    1'b1
`define CS_SEL_RST     2'h0

`endif

// ### logic/ohci_front_pkg.sv
/*
 * Types shared by the front register bank, its checker and its testbench.
 * Assumes the cfg header supplies all numeric constants.
 */
package ohci_front_pkg;

	// Requests to the serial ROM engine
	typedef enum logic [1:0] {
		OP_CLEAR     = 2'h0,
		OP_READ      = 2'h1,
		OP_LOAD_INFO = 2'h2,
		OP_LOAD_BYTE = 2'h3
	} rom_op_t;

	// One command pulse with its operation and byte address
	typedef struct packed {
		logic       go;
		rom_op_t    op;
		logic [7:0] addr;
	} rom_cmd_t;

	// Sequencer states, Gray coded along the boot path
	typedef enum logic [2:0] {
		ST_SAMPLE = 3'h0,
		ST_MINI   = 3'h1,
		ST_INFO   = 3'h3,
		ST_IDLE   = 3'h2,
		ST_CLEAR  = 3'h6,
		ST_READ   = 3'h7
	} seq_state_t;

	// Retry limits of the three transmit units
	typedef struct packed {
		logic [3:0] phys;
		logic [3:0] resp;
		logic [3:0] req;
	} retry_limits_t;

endpackage

// ### logic/tx_retry_counter.sv
/*
 * Retry counter of one transmit unit.
 * Assumes start and busy-ack pulses are synchronous to core_clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module tx_retry_counter
#(
	parameter int CNT_W = 4  // Width of limit and count
)
(
	input  wire logic             core_clk_i,   // System clock
	input  wire logic             rst_n_i,      // Async reset, low
	input  wire logic [CNT_W-1:0] limit_i,      // Configured limit
	input  wire logic             start_i,      // New packet
	input  wire logic             busy_ack_i,   // Busy or data error ack
	output logic                  retry_o,      // Retransmit pulse
	output logic                  give_up_o     // Abandon pulse
);

	logic [CNT_W-1:0] count;       // Retries made for this packet
	logic [CNT_W-1:0] next_count;
	logic             next_retry;
	logic             next_give_up;

	// ------------------------------------------------------------
	// Next count and decision
	// ------------------------------------------------------------
	always_comb
	begin
		next_count   = count;
		next_retry   = 1'b0;
		next_give_up = 1'b0;
		if (start_i)
		begin
			next_count = '0;
		end
		else if (busy_ack_i)
		begin
			// Stop once the count meets the limit; zero means none
			if (count == limit_i)
				next_give_up = 1'b1;
			else
			begin
				next_count = count + 1'b1;
				next_retry = 1'b1;
			end
		end
	end

	// Registers
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count     <= '0;
			retry_o   <= 1'b0;
			give_up_o <= 1'b0;
		end
		else
		begin
			count     <= next_count;
			retry_o   <= next_retry;
			give_up_o <= next_give_up;
		end
	end

endmodule

`default_nettype wire

// ### logic/ohci_front_register_bank.sv
/*
 * Front register bank: version, serial ROM access, transmit retry
 * limits and compare-swap data/control, as a Wishbone classic slave.
 * Assumes a serial ROM engine answering commands with a done pulse,
 * and a compare-swap unit that pulses its finish input.
 */
// Local design decision: register access over Wishbone.
// Function
// - ROM-present flag set when EEPROM detected
// - Autoload bus info on every hardware reset with EEPROM detected
// - Major version field reads 01h
// - Minor version field reads 10h
// - Reserved bits read zero
// - Either reset input clears ROM-present flag
// - Address clear bit set, cleared when done
// - Address clear leaves read byte unchanged
// - Read start bit set, cleared when done
// - Last ROM byte read shown in field
// - Mini offset resets 00h, loaded from 28h
// - Dual-phase retry fields read zero
// - Physical response retry limit, writable
// - Transmit response retry limit, writable
// - Transmit request retry limit, writable
// - Compare-swap data holds new value
// - Done flag set on finish, write clears
// - Two-bit select picks compare-swap resource
`include "ohci_front_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ohci_front_register_bank
	import ohci_front_pkg::*;
#(
	parameter int N_UNITS = 3  // Transmit units: req, resp, phys
)
(
	input  wire logic               core_clk_i,       // System clock
	input  wire logic               rst_n_i,          // Async reset, low
	// Wishbone classic slave
	input  wire logic               wb_cyc_i,         // Cycle
	input  wire logic               wb_stb_i,         // Strobe
	input  wire logic               wb_we_i,          // Write enable
	input  wire logic [7:0]         wb_adr_i,         // Byte address
	input  wire logic [3:0]         wb_sel_i,         // Byte lanes
	input  wire logic [31:0]        wb_dat_i,         // Write data
	output logic [31:0]             wb_dat_o,         // Read data
	output logic                    wb_ack_o,         // Acknowledge
	// Device resets and strap
	input  wire logic               fundamental_reset_in_i, // High
	input  wire logic               global_reset_in_i,      // High
	input  wire logic               eeprom_detect_i,  // EEPROM fitted
	// Serial ROM engine
	output rom_cmd_t                rom_cmd_o,        // Command pulse
	input  wire logic               rom_done_i,       // Command done
	input  wire logic [7:0]         rom_data_i,       // Byte read
	output logic                    mini_rom_valid_o, // Offset usable
	// Compare-swap unit
	output logic [31:0]             cs_new_value_o,   // Swap value
	output logic [1:0]              cs_select_o,      // Resource
	input  wire logic               cs_finish_i,      // Swap finished
	// Transmit retry engines
	input  wire logic [N_UNITS-1:0] tx_start_i,       // New packet
	input  wire logic [N_UNITS-1:0] tx_busy_ack_i,    // Busy ack seen
	output logic [N_UNITS-1:0]      tx_retry_o,       // Retransmit
	output logic [N_UNITS-1:0]      tx_give_up_o      // Abandon
);

	// ------------------------------------------------------------
	// Byte-lane merge
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
				res[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic          ack;              // Registered ack
	logic [31:0]   rdata;            // Registered read data
	logic          next_ack;
	logic [31:0]   next_rdata;

	seq_state_t    state;            // ROM sequencer state
	logic          rom_present_flag; // EEPROM detected
	logic          rom_addr_clear;   // Address clear pending
	logic          rom_read_go;      // Byte read pending
	logic [7:0]    rom_read_byte;    // Last byte read
	logic [7:0]    mini_offset_field;// Mini ROM offset
	retry_limits_t limits;           // Retry limits
	logic [31:0]   cs_data;          // Compare-swap new value
	logic          compare_swap_done;// Swap done flag
	logic [1:0]    compare_swap_resource_select; // Target
	rom_cmd_t      cmd;              // ROM command register
	logic          mini_valid;       // Offset above threshold

	seq_state_t    next_state;
	logic          next_flag;
	logic          next_clear;
	logic          next_go;
	logic [7:0]    next_byte;
	logic [7:0]    next_mini;
	retry_limits_t next_limits;
	logic [31:0]   next_cs_data;
	logic          next_cs_done;
	logic [1:0]    next_cs_sel;
	rom_cmd_t      next_cmd;
	logic          next_mini_valid;

	logic [7:0]    ofs;              // Word-aligned offset
	logic          wr_fire;          // Write takes effect
	logic          hw_reset;         // Either device reset input
	logic [31:0]   retry_word;       // Retry register image
	logic [3:0]    lim_arr [N_UNITS];// Limits per unit

	assign ofs      = {wb_adr_i[7:2], 2'b00};
	assign wr_fire  = wb_cyc_i & wb_stb_i & wb_we_i & ack;
	assign hw_reset = fundamental_reset_in_i | global_reset_in_i;
	// Dual-phase fields and reserved bits read zero
	assign retry_word = {16'h0000, 4'h0, limits};
	assign lim_arr[0] = limits.req;
	assign lim_arr[1] = limits.resp;
	assign lim_arr[2] = limits.phys;

	// ------------------------------------------------------------
	// Bus slave: ack one cycle after the request, then drop
	// ------------------------------------------------------------
	always_comb
	begin
		next_ack   = wb_cyc_i & wb_stb_i & ~ack;
		next_rdata = 32'h0000_0000;
		if (next_ack)
		begin
			case (ofs)
				// Version image with constant fields
				`OFS_VERSION:
					next_rdata = {7'h00, rom_present_flag, `VER_MAJOR,
						8'h00, `VER_MINOR};
				// ROM access image
				`OFS_ROM_ACCESS:
					next_rdata = {rom_addr_clear, 5'h00, rom_read_go,
						1'b0, rom_read_byte, 8'h00, mini_offset_field};
				`OFS_RETRY:
					next_rdata = retry_word;
				`OFS_CS_DATA:
					next_rdata = cs_data;
				`OFS_CS_CTRL:
					next_rdata = {compare_swap_done, 29'h0000_0000,
						compare_swap_resource_select};
				// Unmapped reads zero
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Bus registers
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ack   <= 1'b0;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			ack   <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdata;

	// ------------------------------------------------------------
	// Sequencer and register updates
	// ------------------------------------------------------------
	always_comb
	begin
		next_state      = state;
		next_flag       = rom_present_flag;
		next_clear      = rom_addr_clear;
		next_go         = rom_read_go;
		next_byte       = rom_read_byte;
		next_mini       = mini_offset_field;
		next_limits     = limits;
		next_cs_data    = cs_data;
		next_cs_done    = compare_swap_done;
		next_cs_sel     = compare_swap_resource_select;
		next_cmd        = '{go: 1'b0, op: OP_CLEAR, addr: 8'h00};

		if (hw_reset)
		begin
			// Device reset: drop flag, rerun boot on release
			next_flag  = 1'b0;
			next_clear = 1'b0;
			next_go    = 1'b0;
			next_state = ST_SAMPLE;
		end
		else
		begin
			case (state)
				// Catch strap after reset release
				ST_SAMPLE:
				begin
					if (eeprom_detect_i)
					begin
						next_flag  = 1'b1;
						next_cmd   = '{go: 1'b1, op: OP_LOAD_BYTE,
							addr: `MINI_WORD_ADDR};
						next_state = ST_MINI;
					end
					else
						next_state = ST_IDLE;
				end
				// Wait for the mini offset byte
				ST_MINI:
				begin
					if (rom_done_i)
					begin
						next_mini  = rom_data_i;
						next_cmd   = '{go: 1'b1, op: OP_LOAD_INFO,
							addr: 8'h00};
						next_state = ST_INFO;
					end
				end
				// Wait for bus info quadlet load
				ST_INFO:
				begin
					if (rom_done_i)
						next_state = ST_IDLE;
				end
				// Dispatch software requests, clear first
				ST_IDLE:
				begin
					if (rom_addr_clear)
					begin
						if (rom_present_flag)
						begin
							next_cmd   = '{go: 1'b1, op: OP_CLEAR,
								addr: 8'h00};
							next_state = ST_CLEAR;
						end
						else
							next_clear = 1'b0; // No ROM: finish at once
					end
					else if (rom_read_go)
					begin
						if (rom_present_flag)
						begin
							next_cmd   = '{go: 1'b1, op: OP_READ,
								addr: 8'h00};
							next_state = ST_READ;
						end
						else
							next_go = 1'b0; // No ROM: finish at once
					end
				end
				// Address clear running; read byte untouched
				ST_CLEAR:
				begin
					if (rom_done_i)
					begin
						next_clear = 1'b0;
						next_state = ST_IDLE;
					end
				end
				// Byte read running
				ST_READ:
				begin
					if (rom_done_i)
					begin
						next_byte  = rom_data_i;
						next_go    = 1'b0;
						next_state = ST_IDLE;
					end
				end
				default:
					next_state = ST_IDLE;
			endcase

			// Software sets win over hardware clears
			if (wr_fire && ofs == `OFS_ROM_ACCESS && wb_sel_i[3])
			begin
				if (wb_dat_i[`BIT_ROM_CLEAR])
					next_clear = 1'b1;
				if (wb_dat_i[`BIT_ROM_GO])
					next_go = 1'b1;
			end
		end

		// Retry limits, low two lanes
		if (wr_fire && ofs == `OFS_RETRY)
			next_limits = retry_limits_t'(12'(
				merge(retry_word, wb_dat_i, wb_sel_i)));

		// New value for compare-swap
		if (wr_fire && ofs == `OFS_CS_DATA)
			next_cs_data = merge(cs_data, wb_dat_i, wb_sel_i);

		// Control write clears done and may set select
		if (wr_fire && ofs == `OFS_CS_CTRL)
		begin
			next_cs_done = 1'b0;
			if (wb_sel_i[0])
				next_cs_sel = wb_dat_i[1:0];
		end
		// Finish wins over a clearing write
		if (cs_finish_i)
			next_cs_done = 1'b1;

		// Offset usable only above threshold
		next_mini_valid = (next_mini > `MINI_MIN_VALID);
	end

	// Sequencer and register flip-flops
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state             <= ST_SAMPLE;
			rom_present_flag  <= 1'b0;
			rom_addr_clear    <= 1'b0;
			rom_read_go       <= 1'b0;
			rom_read_byte     <= 8'h00;
			mini_offset_field <= `MINI_RST;
			limits            <= '{`RETRY_RST, `RETRY_RST, `RETRY_RST};
			cs_data           <= 32'h0000_0000;
			compare_swap_done <= `CS_DONE_RST;
			compare_swap_resource_select <= `CS_SEL_RST;
			cmd               <= '{go: 1'b0, op: OP_CLEAR, addr: 8'h00};
			mini_valid        <= 1'b0;
		end
		else
		begin
			state             <= next_state;
			rom_present_flag  <= next_flag;
			rom_addr_clear    <= next_clear;
			rom_read_go       <= next_go;
			rom_read_byte     <= next_byte;
			mini_offset_field <= next_mini;
			limits            <= next_limits;
			cs_data           <= next_cs_data;
			compare_swap_done <= next_cs_done;
			compare_swap_resource_select <= next_cs_sel;
			cmd               <= next_cmd;
			mini_valid        <= next_mini_valid;
		end
	end

	assign rom_cmd_o        = cmd;
	assign mini_rom_valid_o = mini_valid;
	assign cs_new_value_o   = cs_data;
	assign cs_select_o      = compare_swap_resource_select;

	// ------------------------------------------------------------
	// Retry counters, one per transmit unit
	// ------------------------------------------------------------
	for (genvar u = 0; u < N_UNITS; u++)
	begin : g_retry
		// Each unit stops at its own limit
		tx_retry_counter #(
			.CNT_W (4)
		) u_cnt (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.limit_i    (lim_arr[u]),
			.start_i    (tx_start_i[u]),
			.busy_ack_i (tx_busy_ack_i[u]),
			.retry_o    (tx_retry_o[u]),
			.give_up_o  (tx_give_up_o[u])
		);
	end

endmodule

`default_nettype wire

// ### testbench/ohci_front_register_bank_assertions.sv
/* Port checker for the front register bank.
   Assumes it is bound onto ohci_front_register_bank, one clock domain. */
`timescale 1ns/1ns
`default_nettype none

module ohci_front_register_bank_chk
	import ohci_front_pkg::*;
#(
	parameter int N_UNITS = 3  // Transmit units
)
(
	input wire logic               core_clk_i,
	input wire logic               rst_n_i,
	input wire logic               wb_cyc_i,
	input wire logic               wb_stb_i,
	input wire logic               wb_we_i,
	input wire logic [7:0]         wb_adr_i,
	input wire logic [31:0]        wb_dat_o,
	input wire logic               wb_ack_o,
	input wire logic               fundamental_reset_in_i,
	input wire logic               global_reset_in_i,
	input wire rom_cmd_t           rom_cmd_o,
	input wire logic [N_UNITS-1:0] tx_busy_ack_i,
	input wire logic [N_UNITS-1:0] tx_retry_o,
	input wire logic [N_UNITS-1:0] tx_give_up_o
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	wire logic rd_ack;  // Read answer on the bus
	wire logic dev_rst; // Either device reset input
	assign rd_ack = wb_ack_o && !wb_we_i;
	assign dev_rst = fundamental_reset_in_i || global_reset_in_i;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// Relations
	// ------------------------------------------------------------
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	chk_version_bits: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h00 |-> wb_dat_o[31:25] == 7'h00
		&& wb_dat_o[23:0] == 24'h010010) else $error("version word wrong");
	chk_rom_reserved: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h01 |-> wb_dat_o[30:26] == 5'h00
		&& !wb_dat_o[24] && wb_dat_o[15:8] == 8'h00) else $error("rom reserved set");
	chk_retry_upper: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h02 |-> wb_dat_o[31:12] == 20'h00000)
		else $error("dual phase fields not zero");
	chk_flag_reset: assert property (
		rd_ack && wb_adr_i[7:2] == 6'h00 && $past(dev_rst) && $past(dev_rst, 2)
		|-> !wb_dat_o[24]) else $error("flag survives device reset");
	chk_go_pulse: assert property (rom_cmd_o.go |=> !rom_cmd_o.go)
		else $error("rom command pulse too long");
	chk_mini_addr: assert property (
		rom_cmd_o.go && rom_cmd_o.op == OP_LOAD_BYTE |-> rom_cmd_o.addr == 8'h28)
		else $error("mini offset fetched from wrong word");
	chk_retry_answer: assert property (
		tx_busy_ack_i != '0 |=> (tx_retry_o | tx_give_up_o) == $past(tx_busy_ack_i)
		&& (tx_retry_o & tx_give_up_o) == '0) else $error("busy ack answer wrong");
endmodule

bind ohci_front_register_bank ohci_front_register_bank_chk #(.N_UNITS(N_UNITS)) i_chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.fundamental_reset_in_i(fundamental_reset_in_i),
	.global_reset_in_i(global_reset_in_i), .rom_cmd_o(rom_cmd_o),
	.tx_busy_ack_i(tx_busy_ack_i), .tx_retry_o(tx_retry_o),
	.tx_give_up_o(tx_give_up_o));

`default_nettype wire

// ### testbench/ohci_front_register_bank_test.sv
/* Self-checking bench for the front register bank.
   Assumes the bench plays the serial ROM engine and the retry sources. */
`timescale 1ns/1ns
`default_nettype none

module ohci_front_register_bank_test
	import ohci_front_pkg::*;
;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic core_clk_i = 1'b0, rst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, cs_new_value_o, rd;
	logic        wb_ack_o, mini_rom_valid_o, cs_finish_i = 1'b0;
	logic fundamental_reset_in_i = 1'b0, global_reset_in_i = 1'b0, eeprom_detect_i = 1'b1;
	rom_cmd_t    rom_cmd_o;
	rom_op_t     last_op;                 // Last command seen by engine
	logic        rom_done_i = 1'b0;
	logic [7:0]  rom_data_i = 8'h00;
	logic [1:0]  cs_select_o;
	logic [2:0]  tx_start_i = 3'h0, tx_busy_ack_i = 3'h0, tx_retry_o, tx_give_up_o;
	int err_count = 0, samples_checked = 0, cycles = 0, dly = 0, info_cnt = 0;

	typedef struct {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat, exp;} row_t;
	row_t rows[12] = '{
		'{0, 8'h00, 4'hf, 32'h0, 32'h01010010}, '{0, 8'h04, 4'hf, 32'h0, 32'h0000005a},
		'{0, 8'h08, 4'hf, 32'h0, 32'h00000000}, '{1, 8'h08, 4'hf, 32'hffffffff, 32'h0},
		'{0, 8'h08, 4'hf, 32'h0, 32'h00000fff}, '{1, 8'h08, 4'h1, 32'h0, 32'h0},
		'{0, 8'h08, 4'hf, 32'h0, 32'h00000f00}, '{1, 8'h0c, 4'hf, 32'h12345678, 32'h0},
		'{0, 8'h0c, 4'hf, 32'h0, 32'h12345678}, '{0, 8'h14, 4'hf, 32'h0, 32'h80000000},
		'{1, 8'h3c, 4'hf, 32'hffffffff, 32'h0}, '{0, 8'h3c, 4'hf, 32'h0, 32'h00000000}};

	ohci_front_register_bank i_ohci_front_register_bank (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .fundamental_reset_in_i(fundamental_reset_in_i),
		.global_reset_in_i(global_reset_in_i), .eeprom_detect_i(eeprom_detect_i),
		.rom_cmd_o(rom_cmd_o), .rom_done_i(rom_done_i), .rom_data_i(rom_data_i),
		.mini_rom_valid_o(mini_rom_valid_o), .cs_new_value_o(cs_new_value_o),
		.cs_select_o(cs_select_o), .cs_finish_i(cs_finish_i), .tx_start_i(tx_start_i),
		.tx_busy_ack_i(tx_busy_ack_i), .tx_retry_o(tx_retry_o), .tx_give_up_o(tx_give_up_o));

	// ------------------------------------------------------------
	// Clock, timeout and ROM engine stand-in
	// ------------------------------------------------------------
	initial forever #5 core_clk_i = ~core_clk_i;

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			final_report();
		end
		else if (dly == 1 && rom_cmd_o.go !== 1'b1)
		begin
			// Read byte differs from the boot and clear answers
			rom_done_i <= 1'b1;
			rom_data_i <= (last_op == OP_READ) ? 8'hc3 : 8'h5a;
			if (last_op == OP_LOAD_INFO)
				info_cnt++;
			dly <= 0;
		end
		else
		begin
			rom_done_i <= 1'b0;
			rom_data_i <= ~rom_data_i;               // Junk outside answers
			if (rom_cmd_o.go === 1'b1)
			begin
				last_op <= rom_cmd_o.op;
				dly <= 3;
			end
			else if (dly > 1)
				dly <= dly - 1;
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
		input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= dat;
		do
		begin
			@(posedge core_clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic poll(input int b);
		for (int i = 0; i < 20; i++)
		begin
			bus(0, 8'h04, 4'hf, 32'h0);
			if (rd[b] === 1'b0)
				break;
		end
	endtask

	task automatic busy(input logic [2:0] m, input logic [5:0] exp);
		tx_busy_ack_i <= m;
		@(posedge core_clk_i);
		tx_busy_ack_i <= 3'h0;
		@(posedge core_clk_i);
		check({26'h0, tx_give_up_o, tx_retry_o}, {26'h0, exp}, "retry outputs");
	endtask

	task automatic dev_reset(input logic glob, input logic det, input int boots);
		eeprom_detect_i <= det;
		fundamental_reset_in_i <= !glob;
		global_reset_in_i <= glob;
		@(posedge core_clk_i);
		bus(0, 8'h00, 4'hf, 32'h0);
		check(rd[24], 1'b0, "flag during reset");
		fundamental_reset_in_i <= 1'b0;
		global_reset_in_i <= 1'b0;
		for (int i = 0; i < 200 && info_cnt < boots; i++)
			@(posedge core_clk_i);
		repeat (2) @(posedge core_clk_i);
		bus(0, 8'h00, 4'hf, 32'h0);
		check({info_cnt[7:0], rd[24]}, {boots[7:0], det}, "flag after boot");
	endtask

	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 200 && info_cnt < 1; i++)
			@(posedge core_clk_i);
		repeat (2) @(posedge core_clk_i);
		check(mini_rom_valid_o, 1'b1, "mini offset valid");
		foreach (rows[i])
		begin
			bus(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat);
			if (!rows[i].we)
				check(rd, rows[i].exp, "register row");
		end
		check(cs_new_value_o, 32'h12345678, "swap value");
		$display("register table done");
		bus(1, 8'h04, 4'h8, 32'h02000000);
		poll(25);
		check({rd[25], rd[23:16]}, 9'h0c3, "read byte");
		bus(1, 8'h04, 4'h8, 32'h80000000);
		poll(31);
		check({rd[31], rd[23:16], 6'h0, last_op}, 17'h0c300, "addr clear");
		$display("serial rom done");
		bus(1, 8'h08, 4'h1, 32'h00000002);
		tx_start_i <= 3'b011;
		@(posedge core_clk_i);
		tx_start_i <= 3'b000;
		busy(3'b011, 6'b010_001);
		busy(3'b001, 6'b000_001);
		busy(3'b001, 6'b001_000);
		$display("retry done");
		bus(1, 8'h14, 4'hf, 32'h0);
		bus(0, 8'h14, 4'hf, 32'h0);
		check(rd, 32'h00000000, "done cleared");
		cs_finish_i <= 1'b1;
		@(posedge core_clk_i);
		cs_finish_i <= 1'b0;
		bus(0, 8'h14, 4'hf, 32'h0);
		check(rd, 32'h80000000, "done set");
		for (int s = 0; s < 4; s++)
		begin
			bus(1, 8'h14, 4'h1, s);
			check(cs_select_o, s[1:0], "resource select");
		end
		$display("compare swap done");
		dev_reset(1'b0, 1'b0, 1);
		dev_reset(1'b1, 1'b1, 2);
		dev_reset(1'b1, 1'b0, 2);
		$display("device reset done");
		final_report();
	end
endmodule

`default_nettype wire
